// ### opc_power_ctrl.v
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "opc_power_ctrl_regs.vh"
module opc_power_ctrl (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // CPU core events
    input  wire        haltExec,
    input  wire        clrWdogExec,
    input  wire        intRequest,
    input  wire        intEnabled,
    input  wire        stackFull,
    input  wire        wdogOverflow,
    input  wire [7:0]  portaPins,
    // Oscillator status
    input  wire        slowOscReady,
    // CPU and clock controls
    output reg         cpuRun,
    output reg         intServiceNow,
    output reg         resumeAfterHalt,
    output reg         pcSpReset,
    output reg         wdogClear,
    output reg         wdogCountEn,
    output reg         fastOscOn,
    output reg         subClkOn,
    output reg         sysClkEn,
    output reg         sysClkIsSub,
    output reg  [2:0]  sysClkDiv
);

    // Register map, one word each, low bits used:
    //   sys clk ctrl   [7:5] clock select, [1] fast keep,
    //                  [0] slow keep
    //   fast osc ctrl  [3:2] tuning, [1] stable (read only),
    //                  [0] enable
    //   port wake      [7:0] per-pin falling-edge enables
    //   status         [0] powerdown, [1] timeout,
    //                  [2] slow mode, [3] halted (read only)
    //   wdog ctrl      [0] watchdog count enable
    // Unmapped words read zero; writes to them are dropped.
    //
    // Modes and what runs in them:
    //   fast     core on divided fast clock, sub on
    //   slow     core on sub clock, fast per enable bit
    //   sleep    core, fast and sub all stopped
    //   idle_slow_only    core stopped, sub kept
    //   idle_both_clocks    core stopped, fast and sub kept
    //   idle_fast_only    core stopped, fast kept, sub off
    //   wake     core held until its clock is stable
    // The watchdog clock is outside this block and never
    // gated here; only its clear and enable pass through.
    //
    // Wake outcomes, one pulse each, at most one at a time:
    //   watchdog overflow  pc and sp reset, timeout set
    //   interrupt, taken   service now (enabled, stack free)
    //   anything else      resume after the halt
    // A wake by watchdog wins over a coincident interrupt.
    //
    // Limitations:
    //   select writes take effect at once; a switch into
    //   slow mode waits for the slow osc, a switch back
    //   waits for the fast stable flag
    //   only one interrupt line is seen; the core merges
    //   its sources and their enables before this block

    // One-hot modes
    localparam [6:0] ST_FAST  = 7'h01;
    localparam [6:0] ST_SLOW  = 7'h02;
    localparam [6:0] ST_SLEEP = 7'h04;
    localparam [6:0] ST_IDL0  = 7'h08;
    localparam [6:0] ST_IDL1  = 7'h10;
    localparam [6:0] ST_IDL2  = 7'h20;
    localparam [6:0] ST_WAKE  = 7'h40;

    reg [6:0] state;
    reg [2:0] sys_clk_select;
    reg       fast_osc_keep_in_halt;
    reg       slow_osc_keep_in_halt;
    reg       fastOscEnable;
    reg [1:0] fastFreq;
    reg       fast_osc_stable_flag;
    reg [7:0] porta_wake_enable;
    reg       powerdown_flag;
    reg       wdog_timeout_flag;
    reg       wdogEnable;
    reg [7:0] portaPrev;
    reg       intPendAtHalt;
    reg [7:0] fastCnt;
    reg       wakeByWdog;
    reg       wakeByInt;

    // Keep bits pick the halt mode; the select code does not.
    // Sleep is the all-zero case so a cleared register gives
    // the lowest standby current.
    // Halt decode used only by the mode choice on halt
    function [6:0] halt_target;
        input fk;
        input sk;
        begin
            case ({fk, sk})
                2'b00:   halt_target = ST_SLEEP;
                2'b01:   halt_target = ST_IDL0;
                2'b11:   halt_target = ST_IDL1;
                default: halt_target = ST_IDL2;
            endcase
        end
    endfunction

    wire apbWr = psel & penable & pwrite;
    wire apbRd = psel & ~penable & ~pwrite;
    wire regWr = apbWr & (paddr == `OPC_ADDR_SYS_CLK_CTRL);
    wire foWr  = apbWr & (paddr == `OPC_ADDR_FAST_OSC_CTRL);
    wire pwWr  = apbWr & (paddr == `OPC_ADDR_PORTA_WAKE);
    wire wdWr  = apbWr & (paddr == `OPC_ADDR_WDOG_CTRL);
    wire inHalt = (state == ST_SLEEP) | (state == ST_IDL0) |
                  (state == ST_IDL1) | (state == ST_IDL2);
    wire running = (state == ST_FAST) | (state == ST_SLOW);
    wire haltGo = running & haltExec;
    // Falling edge on an enabled port pin
    wire portWake = |(portaPrev & ~portaPins & porta_wake_enable);
    // Only a request that was not already pending may wake
    wire intWake = intRequest & ~intPendAtHalt;
    wire anyWake = inHalt & (portWake | intWake | wdogOverflow);
    // Fast osc need, by mode:
    //   fast mode   always, it clocks the core
    //   slow mode   only while software keeps it enabled
    //   idle_both_clocks/idle_fast_only kept by the fast keep bit
    //   sleep/idle_slow_only stopped, so the stable flag drops
    //   wake        restarting, flag rises after settle
    // Dropping the flag in halt makes the wake wait for a
    // real restart rather than trust a stale stable flag.
    wire inFast   = (state == ST_FAST);
    wire fastKept = (state == ST_IDL1) | (state == ST_IDL2);
    wire fastNeed = running ? (fastOscEnable | inFast)
                            : (fastKept | (state == ST_WAKE));
    // Wake target is the clock source the select code names
    wire wakeToSub = (sys_clk_select == `OPC_SEL_SUB);
    wire wakeDone  = (state == ST_WAKE) &
                     (wakeToSub ? slowOscReady : fast_osc_stable_flag);

    // Zero-wait APB; unmapped reads return zero
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Read data is taken in the setup cycle so it stands
    // through the whole access cycle; a status bit that
    // moves in the access cycle shows on the next read.
    // Register read mux, captured in setup phase
    always @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (apbRd) begin
            case (paddr)
                `OPC_ADDR_SYS_CLK_CTRL:
                    prdata <= {24'h00_0000, sys_clk_select, 3'h0,
                               fast_osc_keep_in_halt,
                               slow_osc_keep_in_halt};
                `OPC_ADDR_FAST_OSC_CTRL:
                    prdata <= {28'h000_0000, fastFreq,
                               fast_osc_stable_flag, fastOscEnable};
                `OPC_ADDR_PORTA_WAKE:
                    prdata <= {24'h00_0000, porta_wake_enable};
                `OPC_ADDR_STATUS:
                    prdata <= {28'h000_0000, inHalt,
                               (state == ST_SLOW),
                               wdog_timeout_flag, powerdown_flag};
                `OPC_ADDR_WDOG_CTRL:
                    prdata <= {31'h0000_0000, wdogEnable};
                default:
                    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Writes land in the access cycle only, so a setup cycle
    // alone never disturbs a register.
    // Software-written configuration
    always @(posedge core_clk) begin
        if (!rst_n) begin
            sys_clk_select        <= `OPC_SEL_RESET;
            fast_osc_keep_in_halt <= 1'b0;
            slow_osc_keep_in_halt <= 1'b0;
            {fastFreq, fastOscEnable} <= 3'h1;
            porta_wake_enable     <= 8'h00;
            wdogEnable            <= `OPC_WDOG_RESET;
        end else begin
            if (regWr) begin
                sys_clk_select <= pwdata[`OPC_SCC_SEL_HI:`OPC_SCC_SEL_LO];
                fast_osc_keep_in_halt <= pwdata[`OPC_SCC_FKEEP];
                slow_osc_keep_in_halt <= pwdata[`OPC_SCC_SKEEP];
            end
            if (foWr) begin
                fastFreq      <= pwdata[`OPC_FOC_FREQ_HI:`OPC_FOC_FREQ_LO];
                fastOscEnable <= pwdata[`OPC_FOC_EN];
            end
            if (pwWr)
                porta_wake_enable <= pwdata[7:0];
            if (wdWr)
                wdogEnable <= pwdata[`OPC_WDOG_EN_BIT];
        end
    end

    // The counter stands in for the real oscillator start-up;
    // it restarts whenever the oscillator is not needed, so
    // every restart, after halt too, waits the full count.
    // A retune while running also restarts it, as the
    // frequency is not trusted until the flag is back.
    // Fast osc settle: flag drops on enable or retune, sets later
    always @(posedge core_clk) begin
        if (!rst_n) begin
            fastCnt              <= `OPC_FAST_SETTLE;
            fast_osc_stable_flag <= 1'b0;
        end else if (!fastNeed ||
                     (foWr && (pwdata[`OPC_FOC_EN] & ~fastOscEnable ||
                      pwdata[`OPC_FOC_FREQ_HI:`OPC_FOC_FREQ_LO]
                      != fastFreq))) begin
            fastCnt              <= `OPC_FAST_SETTLE;
            fast_osc_stable_flag <= 1'b0;
        end else if (fastCnt != `OPC_CNT_ZERO) begin
            fastCnt <= fastCnt - `OPC_CNT_ONE;
        end else begin
            fast_osc_stable_flag <= 1'b1;
        end
    end

    // Halt wins over a clock switch in the same cycle; the
    // switch is then taken after the wake, as the select
    // code is kept. Wake events are only seen in halt modes,
    // so a port edge while running is ignored here.
    // Mode sequencer and status flags
    always @(posedge core_clk) begin
        if (!rst_n) begin
            state             <= ST_FAST;
            powerdown_flag    <= 1'b0;
            wdog_timeout_flag <= 1'b0;
            portaPrev         <= 8'hFF;
            intPendAtHalt     <= 1'b0;
            wakeByWdog        <= 1'b0;
            wakeByInt         <= 1'b0;
        end else begin
            portaPrev <= portaPins;
            if (clrWdogExec & ~haltGo)
                powerdown_flag <= 1'b0;
            case (state)
                ST_FAST, ST_SLOW: begin
                    if (haltGo) begin
                        // Flags change, all other state frozen
                        state             <= halt_target(
                            fast_osc_keep_in_halt,
                            slow_osc_keep_in_halt);
                        powerdown_flag    <= 1'b1;
                        wdog_timeout_flag <= 1'b0;
                        intPendAtHalt     <= intRequest;
                    end else if (state == ST_FAST &&
                                 sys_clk_select == `OPC_SEL_SUB &&
                                 slowOscReady) begin
                        state <= ST_SLOW;
                    end else if (state == ST_SLOW &&
                                 sys_clk_select != `OPC_SEL_SUB &&
                                 fast_osc_stable_flag) begin
                        state <= ST_FAST;
                    end
                end
                ST_SLEEP, ST_IDL0, ST_IDL1, ST_IDL2: begin
                    if (anyWake) begin
                        state      <= ST_WAKE;
                        wakeByWdog <= wdogOverflow;
                        wakeByInt  <= intWake & ~wdogOverflow;
                        if (wdogOverflow)
                            wdog_timeout_flag <= 1'b1;
                    end
                    if (!intRequest)
                        intPendAtHalt <= 1'b0;
                end
                ST_WAKE: begin
                    // Resume on the clock source the select code names
                    if (wakeDone) begin
                        state      <= wakeToSub ? ST_SLOW : ST_FAST;
                        wakeByWdog <= 1'b0;
                        wakeByInt  <= 1'b0;
                    end
                end
                default: state <= ST_FAST;
            endcase
        end
    end

    // All controls are registered so the core and the clock
    // gates see glitch-free levels; the clock gates follow the state one cycle later.
    // Registered CPU and clock controls
    always @(posedge core_clk) begin
        if (!rst_n) begin
            cpuRun          <= 1'b1;
            intServiceNow   <= 1'b0;
            resumeAfterHalt <= 1'b0;
            pcSpReset       <= 1'b0;
            wdogClear       <= 1'b0;
            wdogCountEn     <= 1'b0;
            fastOscOn       <= 1'b1;
            subClkOn        <= 1'b1;
            sysClkEn        <= 1'b1;
            sysClkIsSub     <= 1'b0;
            sysClkDiv       <= 3'h0;
        end else begin
            cpuRun    <= running & ~haltGo;
            wdogClear <= haltGo | clrWdogExec;
            wdogCountEn <= wdogEnable;
            fastOscOn <= fastNeed;
            subClkOn  <= running | (state == ST_IDL0) |
                         (state == ST_IDL1) | (state == ST_WAKE);
            sysClkEn    <= running;
            sysClkIsSub <= (state == ST_SLOW);
            sysClkDiv   <= (sys_clk_select == `OPC_SEL_SUB)
                           ? sysClkDiv : sys_clk_select;
            intServiceNow   <= 1'b0;
            resumeAfterHalt <= 1'b0;
            pcSpReset       <= 1'b0;
            if (wakeDone) begin
                if (wakeByWdog)
                    pcSpReset <= 1'b1;
                else if (wakeByInt && intEnabled && !stackFull)
                    intServiceNow <= 1'b1;
                else
                    resumeAfterHalt <= 1'b1;
            end
        end
    end

endmodule // opc_power_ctrl

// ### opc_power_ctrl_regs.vh
// Notes on behaviour
// - Select code 111 moves clock to sub
// - Codes 000..110 return to divided fast clock
// - Slow switch completes once slow osc stable
// - Fast return waits for fast osc stable
// - Halt with keep bits 00 enters sleep
// - Halt with keep bits 01 enters idle_slow_only
// - Halt with keep bits 11 enters idle_both_clocks
// - Halt with keep bits 10 enters idle_fast_only
// - Halt stops execution, state held unchanged
// - Halt sets powerdown, clears timeout flag
// - Halt clears watchdog; counts only if enabled
// - Wake on port edge, interrupt, watchdog overflow
// - Powerdown cleared by reset or clear-watchdog
// - Halt overflow sets timeout, resets pc, sp
// - Per-pin port wake enable, resume after halt
// - Disabled or stack-full interrupt resumes after halt
// - Enabled interrupt with free stack is serviced
// - Interrupt pending before halt does not wake
// - Wake waits for the oscillator the select code names to be stable
// - Codes 0..6 divide fast by 1..64, 7 sub
// - Fast stable flag clears then sets
`ifndef OPC_POWER_CTRL_REGS_VH
`define OPC_POWER_CTRL_REGS_VH
// APB byte offsets
`define OPC_ADDR_SYS_CLK_CTRL  12'h000
`define OPC_ADDR_FAST_OSC_CTRL 12'h004
`define OPC_ADDR_PORTA_WAKE    12'h008
`define OPC_ADDR_STATUS        12'h00C
`define OPC_ADDR_WDOG_CTRL     12'h010
// System clock control fields
`define OPC_SCC_SEL_HI   7
`define OPC_SCC_SEL_LO   5
`define OPC_SCC_FKEEP    1
`define OPC_SCC_SKEEP    0
`define OPC_SEL_SUB      3'h7
`define OPC_SCC_RESET    8'h00
`define OPC_SEL_RESET    3'h0
// Fast oscillator control fields
`define OPC_FOC_FREQ_HI  3
`define OPC_FOC_FREQ_LO  2
`define OPC_FOC_STABLE   1
`define OPC_FOC_EN       0
`define OPC_FOC_RESET    4'h1
// Status fields
`define OPC_ST_PDF       0
`define OPC_ST_TO        1
`define OPC_ST_SLOWMODE  2
`define OPC_ST_HALTED    3
// Watchdog control
`define OPC_WDOG_EN_BIT  0
`define OPC_WDOG_RESET   1'h1
// Oscillator settle counts in core cycles
`define OPC_FAST_SETTLE  8'h10
`define OPC_SLOW_SETTLE  8'h08
`define OPC_CNT_ZERO     8'h00
`define OPC_CNT_ONE      8'h01
`endif

// ### opc_power_ctrl_sva.sv
`timescale 1ns/10ps
module opc_power_ctrl_sva (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // Core events
    input wire logic       haltExec,
    input wire logic       intRequest,
    input wire logic       intEnabled,
    input wire logic       stackFull,
    input wire logic       wdogOverflow,
    input wire logic       slowOscReady,
    // Controls
    input wire logic       cpuRun,
    input wire logic       intServiceNow,
    input wire logic       resumeAfterHalt,
    input wire logic       pcSpReset,
    input wire logic       wdogClear,
    input wire logic       sysClkIsSub,
    input wire logic [2:0] sysClkDiv
);
    logic halt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Halt counts only while the core runs
    assign halt = haltExec && cpuRun;
    halt_stops_cpu_a: assert property (halt |-> ##[1:2] !cpuRun)
        else $error("core kept running after halt");
    halt_clr_wdog_a: assert property (halt |=> wdogClear)
        else $error("watchdog not cleared on halt");
    wake_excl_a: assert property ($onehot0({intServiceNow,
        resumeAfterHalt, pcSpReset})) else $error("two wake outcomes");
    svc_single_a: assert property (intServiceNow |=> !intServiceNow)
        else $error("service pulse too long");
    wdog_wake_a: assert property (!cpuRun && wdogOverflow
        |-> ##[1:40] pcSpReset) else $error("no pc reset on overflow");
    int_wake_a: assert property ($rose(intRequest) && !cpuRun
        && intEnabled && !stackFull |-> ##[1:40] intServiceNow)
        else $error("no interrupt service on wake");
    int_defer_a: assert property ($rose(intRequest) && !cpuRun
        && !intEnabled |-> ##[1:40] resumeAfterHalt)
        else $error("no resume on wake");
    pend_int_a: assert property (halt && intRequest |-> ##2
        (!intServiceNow && !resumeAfterHalt)[*8])
        else $error("pending interrupt woke core");
    sub_ready_a: assert property ($rose(sysClkIsSub)
        |-> $past(slowOscReady)) else $error("sub clock before ready");
    div_range_a: assert property (sysClkDiv != 3'h7)
        else $error("divider code out of range");
endmodule // opc_power_ctrl_sva
bind opc_power_ctrl opc_power_ctrl_sva chk (.core_clk(core_clk),
    .rst_n(rst_n), .haltExec(haltExec), .intRequest(intRequest),
    .intEnabled(intEnabled), .stackFull(stackFull),
    .wdogOverflow(wdogOverflow), .slowOscReady(slowOscReady),
    .cpuRun(cpuRun), .intServiceNow(intServiceNow),
    .resumeAfterHalt(resumeAfterHalt), .pcSpReset(pcSpReset),
    .wdogClear(wdogClear), .sysClkIsSub(sysClkIsSub),
    .sysClkDiv(sysClkDiv));

// ### opc_cpu_model.sv
`timescale 1ns/10ps
module opc_cpu_model (
    // Clock and oscillator view
    input  wire logic core_clk,
    input  wire logic subClkOn,
    // Instruction and oscillator events
    output logic      haltExec,
    output logic      clrWdogExec,
    output logic      wdogOverflow,
    output logic      slowOscReady
);
    logic [2:0] warm = 3'h0;
    initial {wdogOverflow, clrWdogExec, haltExec, slowOscReady} = 4'h0;
    // Ready lags enable so a hasty switch would be caught
    always @(posedge core_clk) begin
        if (subClkOn !== 1'b1) begin
            warm         <= 3'h0;
            slowOscReady <= 1'b0;
        end else if (warm != 3'h5) begin
            warm <= warm + 3'h1;
        end else begin
            slowOscReady <= 1'b1;
        end
    end
    // One-cycle instruction or overflow pulse
    task automatic instr(input logic [2:0] kind);
        @(posedge core_clk);
        {wdogOverflow, clrWdogExec, haltExec} <= kind;
        @(posedge core_clk);
        {wdogOverflow, clrWdogExec, haltExec} <= 3'h0;
    endtask
endmodule // opc_cpu_model

// ### tb.sv
`timescale 1ns/10ps
`include "opc_power_ctrl_regs.vh"
module tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, intRequest = 1'b0;
    logic        intEnabled = 1'b0, stackFull = 1'b0;
    logic [7:0]  portaPins = 8'hFF;
    logic        haltExec, clrWdogExec, wdogOverflow, slowOscReady;
    logic        cpuRun, intServiceNow, resumeAfterHalt, pcSpReset;
    logic        wdogClear, wdogCountEn, fastOscOn, subClkOn;
    logic        sysClkEn, sysClkIsSub;
    logic [2:0]  sysClkDiv, pulses;
    int          err_total = 0, checks_done = 0, n;
    logic [1:0]  keep [5] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2};
    logic [2:0]  wake [5] = '{3'h2, 3'h2, 3'h4, 3'h2, 3'h1};
    assign pulses = {intServiceNow, resumeAfterHalt, pcSpReset};
    always #25 core_clk = ~core_clk;
    opc_power_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .haltExec(haltExec), .clrWdogExec(clrWdogExec),
        .intRequest(intRequest), .intEnabled(intEnabled),
        .stackFull(stackFull), .wdogOverflow(wdogOverflow),
        .portaPins(portaPins), .slowOscReady(slowOscReady),
        .cpuRun(cpuRun), .intServiceNow(intServiceNow),
        .resumeAfterHalt(resumeAfterHalt), .pcSpReset(pcSpReset),
        .wdogClear(wdogClear), .wdogCountEn(wdogCountEn),
        .fastOscOn(fastOscOn), .subClkOn(subClkOn), .sysClkEn(sysClkEn),
        .sysClkIsSub(sysClkIsSub), .sysClkDiv(sysClkDiv));
    opc_cpu_model cpu (.core_clk(core_clk), .subClkOn(subClkOn),
        .haltExec(haltExec), .clrWdogExec(clrWdogExec),
        .wdogOverflow(wdogOverflow), .slowOscReady(slowOscReady));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A spent wait bound ends the run at once
    task automatic bound(input int cnt);
        if (cnt >= 99) begin
            err_total++;
            $display("[ERR] %0t wait limit reached", $time);
            print_verdict();
        end
    endtask
    // APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge core_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 99);
        bound(k);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic waitWake(input logic [2:0] exp);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pulses === 3'h0 && n < 99);
        bound(n);
        check(32'(pulses), 32'(exp));
    endtask
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge core_clk);
        apb(1'b0, `OPC_ADDR_SYS_CLK_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, `OPC_ADDR_FAST_OSC_CTRL, 32'h0);
        check(rd, 32'h3);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        apb(1'b0, 12'h0FC, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, `OPC_ADDR_WDOG_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        check(32'(wdogCountEn), 32'h0);
        apb(1'b1, `OPC_ADDR_WDOG_CTRL, 32'h1);
        $display("test defaults done");
        // Every select code, ending in slow mode
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `OPC_ADDR_SYS_CLK_CTRL, 32'(c) << 5);
            n = 0;
            while ((sysClkIsSub !== (c == 7) || (c < 7 && sysClkDiv !==
                    3'(c))) && n < 99) begin
                @(posedge core_clk);
                n++;
            end
            bound(n);
            check(32'(sysClkIsSub), 32'(c == 7));
            if (c < 7) check(32'(sysClkDiv), 32'(c));
        end
        apb(1'b0, `OPC_ADDR_STATUS, 32'h0);
        check(rd, 32'h4);
        // Restart fast osc while slow, then return
        apb(1'b1, `OPC_ADDR_FAST_OSC_CTRL, 32'h0);
        apb(1'b1, `OPC_ADDR_FAST_OSC_CTRL, 32'h1);
        apb(1'b0, `OPC_ADDR_FAST_OSC_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, `OPC_ADDR_SYS_CLK_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        check(32'(sysClkIsSub), 32'h1);
        n = 0;
        do begin
            apb(1'b0, `OPC_ADDR_FAST_OSC_CTRL, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 99);
        bound(n);
        repeat (4) @(posedge core_clk);
        check(32'(sysClkIsSub), 32'h0);
        $display("test clock select done");
        // Each halt mode, woken by port edge, interrupt or watchdog overflow
        apb(1'b1, `OPC_ADDR_PORTA_WAKE, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            intEnabled <= (i != 1);
            stackFull  <= (i == 3);
            apb(1'b1, `OPC_ADDR_SYS_CLK_CTRL, 32'(keep[i]));
            cpu.instr(3'h1);
            repeat (4) @(posedge core_clk);
            check(32'({cpuRun, fastOscOn, subClkOn}), 32'(keep[i]));
            apb(1'b0, `OPC_ADDR_STATUS, 32'h0);
            check(rd, 32'h9);
            if (i == 0) portaPins <= 8'hFE;
            else if (i == 4) cpu.instr(3'h4);
            else intRequest <= 1'b1;
            waitWake(wake[i]);
            if (i == 0) check(32'(n > 10), 32'h1);
            portaPins  <= 8'hFF;
            intRequest <= 1'b0;
            repeat (4) @(posedge core_clk);
            check(32'(cpuRun), 32'h1);
        end
        apb(1'b0, `OPC_ADDR_STATUS, 32'h0);
        check(rd, 32'h3);
        cpu.instr(3'h2);
        apb(1'b0, `OPC_ADDR_STATUS, 32'h0);
        check(32'(rd[0]), 32'h0);
        $display("test halt modes done");
        // Request pending at halt must not wake
        intRequest <= 1'b1;
        cpu.instr(3'h1);
        repeat (30) @(posedge core_clk);
        check(32'(cpuRun), 32'h0);
        intRequest <= 1'b0;
        @(posedge core_clk);
        portaPins <= 8'hFE;
        waitWake(3'h2);
        $display("test pending interrupt done");
        print_verdict();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        bound(99);
    end
endmodule // tb
